// file: rtl/alu_flags_addr.sv
// ALU status flags and data operand address generation for an 8-bit core.
// =====================================================================
// Summary of operation
// [RL1] Flag-changing op aimed at status discards result, updates only the flags.
// [RL2] Software changes status only by bit set, bit clear, swap or moves.
// [RL3] Negative flag, bit 4, copies the result's top bit.
// [RL4] Overflow flag, bit 3, marks a wrong sign change in two's complement.
// [RL5] Zero flag, bit 2, is set when the result is zero.
// [RL6] Nibble carry, bit 1, is the carry out of bit 3 on add/subtract.
// [RL7] Carry, bit 0, is the carry out of bit 7 on add/subtract.
// [RL8] Subtract adds the complement plus one, so carries mean no borrow.
// [RL9] Rotates through carry load carry with the bit shifted out.
// [RL10] Status bits 7 to 5 always read zero.
// [RL11] Call and jump carry a 20-bit program target in the instruction.
// [RL12] Bit and byte ops hold an 8-bit file address in the low byte.
// [RL13] With access bit one, bank pointer joins the 8-bit address.
// [RL14] With access bit zero, the address maps into the access bank.
// [RL15] File-to-file move carries full 12-bit addresses, bank pointer ignored.
// [RL16] Destination bit one writes the file, zero writes the accumulator.
// [RL17] Indirect access takes its address from a pointer pair, itself writable.
// [RL18] Virtual operands access through a pointer with increment, decrement, offset.
// [RL19] Indexed literal offset mode exists only when extended set is enabled.
// [RL20] Each pointer is 12 bits and spans data memory linearly.
// [RL21] Plain and offset operands leave pointer and accumulator unchanged.
// [RL22] Pointer steps carry across the pair and touch no flag.
// [RL23] Indirect access to a virtual operand reads 00h, writes nothing.
// [RL24] Flags an op does not affect keep their value.
// [RL25] Status flags are not forced at reset.
`timescale 1ns/100ps
`default_nettype none
`include "alu_core_params.svh"
module alu_flags_addr (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Operation request
  input wire logic i_op_valid,
  input wire alu_core_pkg::alu_op_t i_op,
  input wire alu_core_pkg::addr_mode_t i_addr_mode,
  input wire alu_core_pkg::ind_kind_t i_ind_kind,
  input wire logic [1:0] i_ptr_sel,
  input wire logic [7:0] i_file_addr,
  input wire logic [11:0] i_far_src,
  input wire logic [11:0] i_far_dst,
  input wire logic i_access_bit,
  input wire logic i_dest_bit,
  input wire logic [2:0] i_bit_index,
  input wire logic [7:0] i_file_data,
  input wire logic [7:0] i_acc,
  input wire logic i_extended_set_cfg,
  // Pointer register writes
  input wire logic i_bank_wr,
  input wire logic [3:0] i_bank_data,
  input wire logic i_ptr_wr,
  input wire logic [1:0] i_ptr_wr_sel,
  input wire logic i_ptr_wr_high,
  input wire logic [7:0] i_ptr_wr_data,
  // Results
  output logic [7:0] o_result,
  output logic [11:0] o_src_addr,
  output logic [11:0] o_dst_addr,
  output logic o_mem_wr,
  output logic o_acc_wr,
  output logic [7:0] o_status,
  output logic [3:0] o_bank_pointer,
  output logic [35:0] o_pointers
);
  // =====================================================================
  // Decode helpers
  function automatic logic is_virtual(input logic [11:0] a);
    is_virtual = ((a <= `VIRT_TOP0) && (a >= `VIRT_TOP0 - `VIRT_SPAN)) ||
                 ((a <= `VIRT_TOP1) && (a >= `VIRT_TOP1 - `VIRT_SPAN)) ||
                 ((a <= `VIRT_TOP2) && (a >= `VIRT_TOP2 - `VIRT_SPAN));
  endfunction

  function automatic logic [4:0] flag_mask(input alu_core_pkg::alu_op_t op);
    case (op)
      alu_core_pkg::OP_ADD, alu_core_pkg::OP_SUB: flag_mask = 5'h1f;
      alu_core_pkg::OP_AND, alu_core_pkg::OP_IOR, alu_core_pkg::OP_XOR: flag_mask = 5'h14;
      alu_core_pkg::OP_CLR: flag_mask = 5'h04;
      alu_core_pkg::OP_ROT_LEFT, alu_core_pkg::OP_ROT_RIGHT: flag_mask = 5'h15;
      default: flag_mask = 5'h00;
    endcase
  endfunction

  function automatic logic file_implicit(input alu_core_pkg::alu_op_t op);
    file_implicit = (op == alu_core_pkg::OP_CLR) || (op == alu_core_pkg::OP_BIT_SET) ||
                    (op == alu_core_pkg::OP_BIT_CLEAR) || (op == alu_core_pkg::OP_ACC_TO_FILE);
  endfunction

  // =====================================================================
  // Pointer storage
  logic [11:0] ptr_reg [3];
  logic [3:0] bank_reg;
  logic [11:0] cur_ptr;
  assign cur_ptr = (i_ptr_sel < 2'd3) ? ptr_reg[i_ptr_sel] : `ADDR_ZERO;

  // =====================================================================
  // Operand address generation
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic [11:0] acc_offset;
  assign acc_offset = {{4{i_acc[7]}}, i_acc};

  always_comb begin
    src_addr = `ADDR_ZERO;
    dst_addr = i_far_dst;
    case (i_addr_mode)
      alu_core_pkg::AM_FAR: begin
        src_addr = i_far_src; // RL15
      end
      alu_core_pkg::AM_INDIRECT: begin
        if (i_ind_kind == alu_core_pkg::IND_BEFORE_INCR) begin
          src_addr = cur_ptr + `PTR_STEP; // RL18
        end else if (i_ind_kind == alu_core_pkg::IND_ACC_OFFSET) begin
          src_addr = cur_ptr + acc_offset; // RL21
        end else begin
          src_addr = cur_ptr; // RL17
        end
      end
      default: begin
        if (i_extended_set_cfg && !i_access_bit && i_file_addr <= `IDX_LIMIT) begin
          src_addr = ptr_reg[2] + {4'h0, i_file_addr}; // RL19
        end else if (i_access_bit) begin
          src_addr = {bank_reg, i_file_addr}; // RL13 RL12
        end else if (i_file_addr < `ACC_SPLIT) begin
          src_addr = {`ACC_LOW_BANK, i_file_addr}; // RL14
        end else begin
          src_addr = {`ACC_HIGH_BANK, i_file_addr}; // RL14
        end
      end
    endcase
    if (i_addr_mode != alu_core_pkg::AM_FAR) begin
      dst_addr = src_addr;
    end
  end

  logic virt_hit;
  assign virt_hit = (i_addr_mode == alu_core_pkg::AM_INDIRECT) && is_virtual(src_addr); // RL23

  // =====================================================================
  // Arithmetic and logic
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic [4:0] fl_new;
  assign opa = virt_hit ? `BYTE_ZERO : i_file_data; // RL23
  assign opb = (i_op == alu_core_pkg::OP_SUB) ? ~i_acc : i_acc; // RL8
  assign cin = (i_op == alu_core_pkg::OP_SUB);
  assign sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  assign sum5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};

  always_comb begin
    case (i_op)
      alu_core_pkg::OP_ADD, alu_core_pkg::OP_SUB: res = sum9[7:0];
      alu_core_pkg::OP_AND: res = opa & i_acc;
      alu_core_pkg::OP_IOR: res = opa | i_acc;
      alu_core_pkg::OP_XOR: res = opa ^ i_acc;
      alu_core_pkg::OP_CLR: res = `BYTE_ZERO;
      alu_core_pkg::OP_ROT_LEFT: res = {opa[6:0], o_status[`SR_CARRY]};
      alu_core_pkg::OP_ROT_RIGHT: res = {o_status[`SR_CARRY], opa[7:1]};
      alu_core_pkg::OP_BIT_SET: res = opa | (8'h01 << i_bit_index);
      alu_core_pkg::OP_BIT_CLEAR: res = opa & ~(8'h01 << i_bit_index);
      alu_core_pkg::OP_NIBBLE_SWAP: res = {opa[3:0], opa[7:4]};
      alu_core_pkg::OP_ACC_TO_FILE: res = i_acc;
      default: res = opa;
    endcase
    fl_new[`SR_NEG] = res[7]; // RL3
    fl_new[`SR_OVF] = (opa[7] == opb[7]) && (res[7] != opa[7]); // RL4
    fl_new[`SR_ZERO] = (res == `BYTE_ZERO); // RL5
    fl_new[`SR_NIB] = sum5[4]; // RL6 RL8
    fl_new[`SR_CARRY] = sum9[8]; // RL7 RL8
    if (i_op == alu_core_pkg::OP_ROT_LEFT) begin
      fl_new[`SR_CARRY] = opa[7]; // RL9
    end else if (i_op == alu_core_pkg::OP_ROT_RIGHT) begin
      fl_new[`SR_CARRY] = opa[0]; // RL9
    end
  end

  // =====================================================================
  // Destination steering
  logic to_file;
  logic to_status;
  logic [4:0] mask;
  assign to_file = (i_addr_mode == alu_core_pkg::AM_FAR) || i_dest_bit || file_implicit(i_op); // RL16
  assign to_status = to_file && (dst_addr == `STATUS_ADDR) && !virt_hit;
  assign mask = flag_mask(i_op);

  // Flags carry no reset value; software must set them before relying on them.
  always_ff @(posedge i_clock) begin
    o_status[7:5] <= 3'b000; // RL10
    if (i_op_valid && to_status && mask == 5'h00) begin
      o_status[4:0] <= res[4:0]; // RL2
    end else if (i_op_valid) begin
      o_status[4:0] <= (fl_new & mask) | (o_status[4:0] & ~mask); // RL1 RL24 RL25
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_result <= `BYTE_ZERO;
      o_src_addr <= `ADDR_ZERO;
      o_dst_addr <= `ADDR_ZERO;
      o_mem_wr <= 1'b0;
      o_acc_wr <= 1'b0;
    end else begin
      o_result <= res;
      o_src_addr <= src_addr;
      o_dst_addr <= dst_addr;
      // Status is held here, so a write aimed at it never reaches memory.
      o_mem_wr <= i_op_valid && to_file && !to_status && !virt_hit; // RL1 RL23
      o_acc_wr <= i_op_valid && !to_file; // RL16
    end
  end

  // =====================================================================
  // Bank and pointer registers
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      bank_reg <= 4'h0;
      o_bank_pointer <= 4'h0;
    end else if (i_bank_wr) begin
      bank_reg <= i_bank_data;
      o_bank_pointer <= i_bank_data;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      logic hit;
      assign hit = i_op_valid && (i_addr_mode == alu_core_pkg::AM_INDIRECT) &&
                   (i_ptr_sel == 2'(gi));
      // A direct write wins over an auto step in the same cycle.
      always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
          ptr_reg[gi] <= `ADDR_ZERO;
        end else if (i_ptr_wr && i_ptr_wr_sel == 2'(gi)) begin
          if (i_ptr_wr_high) begin
            ptr_reg[gi][11:8] <= i_ptr_wr_data[3:0]; // RL17 RL20
          end else begin
            ptr_reg[gi][7:0] <= i_ptr_wr_data; // RL17
          end
        end else if (hit && (i_ind_kind == alu_core_pkg::IND_AFTER_INCR ||
                             i_ind_kind == alu_core_pkg::IND_BEFORE_INCR)) begin
          ptr_reg[gi] <= ptr_reg[gi] + `PTR_STEP; // RL22 RL21
        end else if (hit && i_ind_kind == alu_core_pkg::IND_AFTER_DECR) begin
          ptr_reg[gi] <= ptr_reg[gi] - `PTR_STEP; // RL22 RL21
        end
      end
      always_ff @(posedge i_clock) begin
        o_pointers[gi*12 +: 12] <= (!i_rstn) ? `ADDR_ZERO : ptr_reg[gi];
      end
    end
  endgenerate

  // =====================================================================
  // Checks
  sequence seq_add_req;
    i_op_valid && i_op == alu_core_pkg::OP_ADD && !to_status;
  endsequence
  sequence seq_after_incr_operand_req;
    i_op_valid && i_addr_mode == alu_core_pkg::AM_INDIRECT &&
    i_ind_kind == alu_core_pkg::IND_AFTER_INCR && !i_ptr_wr && i_ptr_sel == 2'd0;
  endsequence

  a_status_high_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL10
    $past(i_rstn) |-> o_status[7:5] == 3'b000) else $error("status high bits not zero");
  a_neg_tracks_msb: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL3
    seq_add_req |=> o_status[4] == o_result[7]) else $error("negative flag wrong");
  a_zero_tracks: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL5
    seq_add_req |=> o_status[2] == (o_result == 8'h00)) else $error("zero flag wrong");
  a_carry_add: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL7
    seq_add_req ##0 !virt_hit |=> o_status[0] ==
      (({1'b0, $past(i_file_data)} + {1'b0, $past(i_acc)}) > 9'h0ff))
    else $error("carry flag wrong");
  a_flags_held: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL24
    i_op_valid && i_op == alu_core_pkg::OP_NIBBLE_SWAP && !to_status
    |=> o_status[4:0] == $past(o_status[4:0])) else $error("flags changed");
  a_status_discard: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL1
    i_op_valid && to_status |=> !o_mem_wr) else $error("status result written");
  a_bank_join: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL13
    i_addr_mode == alu_core_pkg::AM_DIRECT && i_access_bit
    |=> o_src_addr == {$past(bank_reg), $past(i_file_addr)}) else $error("bank address wrong");
  a_ptr_step: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL22
    seq_after_incr_operand_req |=> ##1 o_pointers[11:0] == $past(ptr_reg[0], 2) + 12'h001)
    else $error("pointer step wrong");
  a_virt_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL23
    i_op_valid && virt_hit |=> !o_mem_wr) else $error("virtual write made");
  a_clear_status: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL1
    i_op_valid && i_op == alu_core_pkg::OP_CLR && to_status
    |=> o_status[`SR_ZERO] && !o_mem_wr &&
      o_status[4:3] == $past(o_status[4:3]) && o_status[1:0] == $past(o_status[1:0]))
    else $error("clear of status wrong");
  a_rotate_carry: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL9
    i_op_valid && i_op == alu_core_pkg::OP_ROT_LEFT && !to_status
    |=> o_status[`SR_CARRY] == $past(opa[7])) else $error("rotate carry wrong");
  a_sub_borrow: assert property (@(posedge i_clock) disable iff (!i_rstn) // RL8
    i_op_valid && i_op == alu_core_pkg::OP_SUB && !to_status && !virt_hit
    |=> o_status[0] == ($past(i_file_data) >= $past(i_acc))) else $error("borrow wrong");
endmodule
`default_nettype wire

// file: rtl/alu_core_params.svh
// Constants for the ALU flag and operand address block.
`ifndef ALU_CORE_PARAMS_SVH
`define ALU_CORE_PARAMS_SVH
`define SR_NEG 4
`define SR_OVF 3
`define SR_ZERO 2
`define SR_NIB 1
`define SR_CARRY 0
`define SR_IMPL_MASK 8'h1f
`define ACC_SPLIT 8'h60
`define IDX_LIMIT 8'h5f
`define ACC_LOW_BANK 4'h0
`define ACC_HIGH_BANK 4'hf
`define STATUS_ADDR 12'hfd8
`define VIRT_TOP0 12'hfef
`define VIRT_TOP1 12'hfe7
`define VIRT_TOP2 12'hfdf
`define VIRT_SPAN 12'h004
`define PTR_STEP 12'h001
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 12'h000
`endif

// file: rtl/alu_core_pkg.sv
// Types shared by the ALU flag and operand address block.
package alu_core_pkg;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR,
    OP_ROT_LEFT, OP_ROT_RIGHT, OP_BIT_SET, OP_BIT_CLEAR,
    OP_NIBBLE_SWAP, OP_ACC_TO_FILE, OP_FILE_TO_FILE
  } alu_op_t;
  typedef enum logic [1:0] {AM_DIRECT, AM_INDIRECT, AM_FAR} addr_mode_t;
  typedef enum logic [2:0] {
    IND_PLAIN, IND_AFTER_INCR, IND_AFTER_DECR, IND_BEFORE_INCR, IND_ACC_OFFSET
  } ind_kind_t;
endpackage

// file: tb/alu_flags_addr_tb.sv
// Self-checking testbench for the ALU flag and operand address block.
`timescale 1ns/100ps
`default_nettype none
module alu_flags_addr_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  alu_core_pkg::alu_op_t op = alu_core_pkg::OP_ADD;
  alu_core_pkg::addr_mode_t addr_mode = alu_core_pkg::AM_DIRECT;
  alu_core_pkg::ind_kind_t ind_kind = alu_core_pkg::IND_PLAIN;
  alu_core_pkg::ind_kind_t kn = alu_core_pkg::IND_PLAIN;
  logic [1:0] ptr_sel = 2'h0;
  logic [1:0] sn = 2'h0;
  logic [7:0] file_addr = 8'h00;
  logic [7:0] file_data = 8'h00;
  logic [7:0] acc = 8'h00;
  logic access_bit = 1'b0;
  logic dest_bit = 1'b0;
  logic ext_cfg = 1'b0;
  logic xn = 1'b0;
  logic [2:0] bit_index = 3'h0;
  logic [2:0] bn = 3'h0;
  alu_core_pkg::ind_kind_t ks [5] = '{alu_core_pkg::IND_AFTER_INCR,
    alu_core_pkg::IND_AFTER_DECR, alu_core_pkg::IND_BEFORE_INCR,
    alu_core_pkg::IND_PLAIN, alu_core_pkg::IND_ACC_OFFSET};
  logic [11:0] es [5] = '{12'h0ff, 12'h100, 12'h100, 12'h100, 12'h0fe};
  logic [11:0] ep [5] = '{12'h100, 12'h0ff, 12'h100, 12'h100, 12'h100};
  logic bank_wr = 1'b0;
  logic [3:0] bank_data = 4'h0;
  logic ptr_wr = 1'b0;
  logic [1:0] ptr_wr_sel = 2'h0;
  logic ptr_wr_high = 1'b0;
  logic [7:0] ptr_wr_data = 8'h00;
  logic [7:0] result;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic mem_wr;
  logic acc_wr;
  logic [7:0] status;
  logic [3:0] bank_ptr;
  logic [35:0] pointers;
  int n_mismatch = 0;
  int n_compared = 0;

  alu_flags_addr i_alu_flags_addr (
    .i_clock(clock), .i_rstn(rstn), .i_op_valid(op_valid), .i_op(op),
    .i_addr_mode(addr_mode), .i_ind_kind(ind_kind), .i_ptr_sel(ptr_sel),
    .i_file_addr(file_addr), .i_far_src(12'h123), .i_far_dst(12'h456),
    .i_access_bit(access_bit), .i_dest_bit(dest_bit), .i_bit_index(bit_index),
    .i_file_data(file_data), .i_acc(acc), .i_extended_set_cfg(ext_cfg),
    .i_bank_wr(bank_wr), .i_bank_data(bank_data), .i_ptr_wr(ptr_wr),
    .i_ptr_wr_sel(ptr_wr_sel), .i_ptr_wr_high(ptr_wr_high), .i_ptr_wr_data(ptr_wr_data),
    .o_result(result), .o_src_addr(src_addr), .o_dst_addr(dst_addr), .o_mem_wr(mem_wr),
    .o_acc_wr(acc_wr), .o_status(status), .o_bank_pointer(bank_ptr), .o_pointers(pointers)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #25 clock = ~clock;
  end

  // The tests need some 75 cycles; forty times that means a hang.
  initial begin
    #(3000 * 50);
    n_mismatch++;
    final_report();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One request; returns just after the edge that presents its answer.
  task automatic run(input alu_core_pkg::alu_op_t p, input alu_core_pkg::addr_mode_t m,
      input logic [7:0] fa, input logic [7:0] d, input logic [7:0] a, input logic ab,
      input logic db);
    @(posedge clock);
    op_valid <= 1'b1;
    op <= p;
    addr_mode <= m;
    ind_kind <= kn;
    ptr_sel <= sn;
    file_addr <= fa;
    file_data <= d;
    acc <= a;
    access_bit <= ab;
    dest_bit <= db;
    ext_cfg <= xn;
    bit_index <= bn;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic pw(input logic [1:0] s, input logic hi, input logic [7:0] v);
    @(posedge clock);
    ptr_wr <= 1'b1;
    ptr_wr_sel <= s;
    ptr_wr_high <= hi;
    ptr_wr_data <= v;
    @(posedge clock);
    ptr_wr <= 1'b0;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk(status[7:5], 3'h0);
    chk(pointers[11:0], 12'h000);
    @(posedge clock);
    bank_wr <= 1'b1;
    bank_data <= 4'h3;
    @(posedge clock);
    bank_wr <= 1'b0;
    run(alu_core_pkg::OP_ADD, alu_core_pkg::AM_DIRECT, 8'h10, 8'hf0, 8'h20, 1'b1, 1'b1);
    chk(result, 8'h10);
    chk(src_addr, 12'h310);
    chk({mem_wr, acc_wr}, 2'h2);
    chk(status, 8'h01);
    run(alu_core_pkg::OP_ADD, alu_core_pkg::AM_DIRECT, 8'h20, 8'h7f, 8'h01, 1'b0, 1'b0);
    chk(src_addr, 12'h020);
    chk({mem_wr, acc_wr}, 2'h1);
    chk(status, 8'h1a);
    run(alu_core_pkg::OP_SUB, alu_core_pkg::AM_DIRECT, 8'h90, 8'h05, 8'h05, 1'b0, 1'b0);
    chk(src_addr, 12'hf90);
    chk(status, 8'h07);
    run(alu_core_pkg::OP_SUB, alu_core_pkg::AM_DIRECT, 8'h90, 8'h00, 8'h01, 1'b0, 1'b0);
    chk(status, 8'h10);
    run(alu_core_pkg::OP_SUB, alu_core_pkg::AM_DIRECT, 8'h90, 8'h80, 8'h01, 1'b0, 1'b0);
    chk(status, 8'h09);
    $display("test arithmetic done");
    run(alu_core_pkg::OP_ROT_LEFT, alu_core_pkg::AM_DIRECT, 8'h90, 8'h81, 8'h00, 1'b0, 1'b0);
    chk(result, 8'h03);
    chk(status, 8'h09);
    run(alu_core_pkg::OP_ROT_RIGHT, alu_core_pkg::AM_DIRECT, 8'h90, 8'h02, 8'h00, 1'b0, 1'b0);
    chk(result, 8'h81);
    chk(status, 8'h18);
    run(alu_core_pkg::OP_CLR, alu_core_pkg::AM_DIRECT, 8'hd8, 8'h55, 8'h00, 1'b0, 1'b1);
    chk(status, 8'h1c);
    chk(mem_wr, 1'b0);
    run(alu_core_pkg::OP_AND, alu_core_pkg::AM_DIRECT, 8'h90, 8'h0f, 8'hf0, 1'b0, 1'b0);
    chk(status, 8'h0c);
    run(alu_core_pkg::OP_BIT_SET, alu_core_pkg::AM_DIRECT, 8'hd8, 8'h0c, 8'h00, 1'b0, 1'b1);
    chk(status, 8'h0d);
    bn = 3'h2;
    run(alu_core_pkg::OP_BIT_CLEAR, alu_core_pkg::AM_DIRECT, 8'hd8, 8'h0d, 8'h00, 1'b0, 1'b1);
    chk(status, 8'h09);
    run(alu_core_pkg::OP_NIBBLE_SWAP, alu_core_pkg::AM_DIRECT, 8'h90, 8'h12, 8'h00, 1'b0, 1'b0);
    chk(result, 8'h21);
    chk(status, 8'h09);
    run(alu_core_pkg::OP_XOR, alu_core_pkg::AM_DIRECT, 8'h90, 8'haa, 8'haa, 1'b0, 1'b0);
    chk(status, 8'h0d);
    $display("test status done");
    run(alu_core_pkg::OP_FILE_TO_FILE, alu_core_pkg::AM_FAR, 8'h00, 8'h5a, 8'h00, 1'b1, 1'b1);
    chk(src_addr, 12'h123);
    chk(dst_addr, 12'h456);
    chk(result, 8'h5a);
    pw(2'h0, 1'b0, 8'hff);
    pw(2'h0, 1'b1, 8'h00);
    for (int i = 0; i < 5; i++) begin
      kn = ks[i];
      run(alu_core_pkg::OP_ACC_TO_FILE, alu_core_pkg::AM_INDIRECT, 8'h00, 8'h00, 8'hfe, 1'b0,
        1'b1);
      chk(src_addr, es[i]);
      chk(acc_wr, 1'b0);
      @(posedge clock);
      #1;
      chk(pointers[11:0], ep[i]);
      chk(status, 8'h0d);
    end
    pw(2'h1, 1'b0, 8'he7);
    pw(2'h1, 1'b1, 8'h0f);
    kn = alu_core_pkg::IND_PLAIN;
    sn = 2'h1;
    run(alu_core_pkg::OP_IOR, alu_core_pkg::AM_INDIRECT, 8'h00, 8'h55, 8'h00, 1'b0, 1'b1);
    chk(result, 8'h00);
    chk(mem_wr, 1'b0);
    chk(pointers[23:12], 12'hfe7);
    $display("test indirect done");
    pw(2'h2, 1'b0, 8'h00);
    pw(2'h2, 1'b1, 8'h02);
    xn = 1'b1;
    run(alu_core_pkg::OP_ACC_TO_FILE, alu_core_pkg::AM_DIRECT, 8'h05, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(dst_addr, 12'h205);
    run(alu_core_pkg::OP_ACC_TO_FILE, alu_core_pkg::AM_DIRECT, 8'h60, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(dst_addr, 12'hf60);
    xn = 1'b0;
    run(alu_core_pkg::OP_ACC_TO_FILE, alu_core_pkg::AM_DIRECT, 8'h05, 8'h00, 8'h00, 1'b0, 1'b1);
    chk(dst_addr, 12'h005);
    $display("test extended done");
    final_report();
  end
endmodule
`default_nettype wire
